// ==== scd_clock_power.sv ====
// Purpose: sample clock divider, duty cycle stabilizer model and power-state control
// Assumes: core_clk is the sample clock; all pins asynchronous to it
// Notes:   divided clock leaves as an enable pulse plus a shaped level
`timescale 1ns/100ps
`default_nettype none
module scd_clock_power
	import scd_pkg::*;
#(
	parameter int RECHARGE_CYC  = 2000,
	parameter int STBY_WAKE_CYC = 200
) (
	input  wire logic  core_clk,
	input  wire logic  rst,
	input  wire logic  sclk_pin,
	input  wire logic  csb_n_pin,
	input  wire logic  sdio_in,
	output logic       sdio_out,
	output logic       sdio_oe,
	input  wire logic  align_strobe_pin,
	input  wire logic  low_power_request_pin,
	output logic       conv_en,
	output logic       conv_clk,
	output scd_pwr_t   pwr
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// Wake check below watches eight quiet cycles, so shorter wakes are refused
	localparam int WAKE_MIN_CYC = 8;

	if (RECHARGE_CYC < WAKE_MIN_CYC || RECHARGE_CYC >= (1 << TMR_W)) begin : g_chk_rc
		$error("RECHARGE_CYC out of timer range");
	end
	if (STBY_WAKE_CYC < WAKE_MIN_CYC || STBY_WAKE_CYC >= (1 << TMR_W)) begin : g_chk_sw
		$error("STBY_WAKE_CYC out of timer range");
	end
	if (LOCK_CYC >= (1 << TMR_W)) begin : g_chk_lk
		$error("LOCK_CYC out of timer range");
	end

	localparam logic [TMR_W-1:0] LOCK_LD  = TMR_W'(LOCK_CYC);
	localparam logic [TMR_W-1:0] RCHG_LD  = TMR_W'(RECHARGE_CYC);
	localparam logic [TMR_W-1:0] STBY_LD  = TMR_W'(STBY_WAKE_CYC);

	scd_state_t       st_r;
	scd_state_t       st_nxt;
	logic [SY_W-1:0]  sy;
	logic             lock_done;
	logic             wake_done;

	// Combinational helpers
	logic             sclk_rise;
	logic             sclk_fall;
	logic             sync_edge;
	logic             accept;
	logic             pd_any;
	logic             stby;
	logic             lp_now;
	logic             wake_start;
	logic             lock_start;
	logic             wr_commit;
	logic             hdr_done;
	logic [15:0]      sh_in;
	logic [7:0]       rdata;
	logic [2:0]       half;
	logic             dcs_active;
	logic             clk_on;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	scd_sync2 #(
		.W       (SY_W),
		.RST_VAL (SY_RST)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.d        ({low_power_request_pin, align_strobe_pin, sdio_in, csb_n_pin, sclk_pin}),
		.q        (sy)
	);

	// ****************************************************************
	// Stabilizer lock and wake timers
	// ****************************************************************
	scd_timer #(
		.W (TMR_W)
	) u_lock (
		.core_clk (core_clk),
		.rst      (rst),
		.start    (lock_start),
		.load     (LOCK_LD),
		.done     (lock_done)
	);

	scd_timer #(
		.W (TMR_W)
	) u_wake (
		.core_clk (core_clk),
		.rst      (rst),
		.start    (wake_start),
		.load     (st_r.pd_d ? RCHG_LD : STBY_LD),
		.done     (wake_done)
	);

	// ****************************************************************
	// Read data mux
	// ****************************************************************
	// Decoded from the incoming header, so a read answers its own address
	always_comb begin
		rdata = 8'h00;
		if (sh_in[12:0] == REG_PWR) begin
			rdata[1:0] = st_r.pwr_mode;
		end else if (sh_in[12:0] == REG_DCS) begin
			rdata[DCS_EN_BIT] = st_r.dcs_en;
		end else if (sh_in[12:0] == REG_STAT) begin
			rdata[3:0] = {st_r.dcs_on, st_r.pwr.ready, st_r.armed, st_r.lp_d};
		end else if (sh_in[12:0] == REG_DIV) begin
			rdata[2:0] = st_r.div_m1;
		end else if (sh_in[12:0] == REG_ALIGN) begin
			rdata[ALIGN_ONCE_BIT:ALIGN_EN_BIT] = st_r.align_ctl;
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_nxt     = st_r;
		sclk_rise  = sy[SY_SCLK] && !st_r.sclk_d;
		sclk_fall  = !sy[SY_SCLK] && st_r.sclk_d;
		sh_in      = {st_r.sh[14:0], sy[SY_SDIO]};
		hdr_done   = sclk_rise && !sy[SY_CSB] && (st_r.bitcnt == HDR_BITS - 5'h01);
		wr_commit  = sclk_rise && !sy[SY_CSB] && !st_r.rd
			&& (st_r.bitcnt == FRAME_BITS - 5'h01);
		st_nxt.sclk_d = sy[SY_SCLK];
		st_nxt.sync_d = sy[SY_SYNC];

		// Serial port framing
		if (sy[SY_CSB]) begin
			st_nxt.bitcnt  = 5'h00;
			st_nxt.rd      = 1'b0;
			st_nxt.sdio_oe = 1'b0;
		end else if (sclk_rise && st_r.bitcnt != FRAME_BITS) begin
			st_nxt.bitcnt = st_r.bitcnt + 5'h01;
			// Read data leaves on falling edges only
			if (!st_r.rd) begin
				st_nxt.sh = sh_in;
			end
			if (hdr_done) begin
				st_nxt.rd   = sh_in[RW_BIT];
				st_nxt.addr = sh_in[12:0];
				if (sh_in[RW_BIT]) begin
					st_nxt.sh = {rdata, 8'h00};
				end
			end
		end else if (sclk_fall && st_r.rd && st_r.bitcnt >= HDR_BITS
			&& st_r.bitcnt < FRAME_BITS) begin
			st_nxt.sdio_out = st_r.sh[15];
			st_nxt.sdio_oe  = 1'b1;
			st_nxt.sh       = {st_r.sh[14:0], 1'b0};
		end

		// Configuration writes take effect at once
		if (wr_commit) begin
			if (st_r.addr == REG_PWR) begin
				st_nxt.pwr_mode = sh_in[1:0];
			end else if (st_r.addr == REG_DCS) begin
				st_nxt.dcs_en = sh_in[DCS_EN_BIT];
			end else if (st_r.addr == REG_DIV) begin
				st_nxt.div_m1 = sh_in[2:0];
			end else if (st_r.addr == REG_ALIGN) begin
				st_nxt.align_ctl = sh_in[ALIGN_ONCE_BIT:ALIGN_EN_BIT];
				st_nxt.armed     = 1'b1;
			end
		end

		// Power state: pin or port bit
		pd_any     = sy[SY_LOW_POWER_REQUEST_PIN] || (st_r.pwr_mode == PWR_DOWN);
		stby       = !pd_any && (st_r.pwr_mode == PWR_STBY);
		lp_now     = pd_any || stby;
		wake_start = st_r.lp_d && !lp_now;
		st_nxt.lp_d = lp_now;
		if (lp_now) begin
			st_nxt.pd_d = pd_any;
		end
		st_nxt.pwr.drv_oe  = !pd_any;
		st_nxt.pwr.ref_en  = !pd_any;
		st_nxt.pwr.bias_en = !lp_now;
		st_nxt.pwr.clk_en  = !lp_now;
		st_nxt.pwr.ready   = !lp_now && !wake_start && wake_done;
		clk_on = !lp_now;

		// Relock after any divide ratio write or stabilizer turn-on
		lock_start = (wr_commit && st_r.addr == REG_DIV)
			|| (wr_commit && st_r.addr == REG_DCS && sh_in[DCS_EN_BIT] && !st_r.dcs_en)
			|| wake_start;
		dcs_active = st_r.dcs_en && DCS_RATE_OK && lock_done && !lock_start;
		st_nxt.dcs_on = dcs_active;

		// Alignment strobe acceptance
		sync_edge = sy[SY_SYNC] && !st_r.sync_d;
		accept    = sync_edge && st_r.align_ctl[0]
			&& (!st_r.align_ctl[1] || st_r.armed);
		// A write in the same cycle re-arms: set wins
		if (accept && st_r.align_ctl[1] && !(wr_commit && st_r.addr == REG_ALIGN)) begin
			st_nxt.armed = 1'b0;
		end

		// Divider; shortened ratios wrap at once
		if (!clk_on) begin
			st_nxt.cnt = 3'h0;
		end else if (accept) begin
			st_nxt.cnt = 3'h0;
		end else if (st_r.cnt >= st_r.div_m1) begin
			st_nxt.cnt = 3'h0;
		end else begin
			st_nxt.cnt = st_r.cnt + 3'h1;
		end
		st_nxt.conv_en = clk_on && (st_nxt.cnt == 3'h0);

		// Stabilized clock: high for the first half of each period, rounded up for odd ratios
		half = st_r.div_m1 >> 1;
		if (!clk_on) begin
			st_nxt.conv_clk = 1'b0;
		end else if (dcs_active) begin
			st_nxt.conv_clk = (st_nxt.cnt <= half);
		end else begin
			st_nxt.conv_clk = (st_nxt.cnt == 3'h0);
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r           <= '0;
			st_r.div_m1    <= DIV_M1_RST;
			st_r.align_ctl <= ALIGN_RST;
			st_r.dcs_en    <= DCS_RST;
			st_r.pwr_mode  <= PWR_NORMAL;
			st_r.sclk_d    <= SY_RST[SY_SCLK];
			st_r.sync_d    <= SY_RST[SY_SYNC];
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sdio_out = st_r.sdio_out;
	assign sdio_oe  = st_r.sdio_oe;
	assign conv_en  = st_r.conv_en;
	assign conv_clk = st_r.conv_clk;
	assign pwr      = st_r.pwr;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_div_period: assert property (@(posedge core_clk) disable iff (rst)
		(st_r.cnt == st_r.div_m1 && clk_on && !accept) |=> st_r.conv_en)
		else $error("divider missed its period end");

	a_sync_restart: assert property (@(posedge core_clk) disable iff (rst)
		(accept && clk_on) |=> (st_r.cnt == 3'h0 && st_r.conv_en))
		else $error("accepted strobe did not restart divider");

	a_once_disarm: assert property (@(posedge core_clk) disable iff (rst)
		(accept && st_r.align_ctl[1] && !wr_commit) |=> !st_r.armed ##1 !accept || !st_r.align_ctl[1] || st_r.armed)
		else $error("one-shot alignment not disarmed");

	a_sync_edge_src: assert property (@(posedge core_clk) disable iff (rst)
		accept |-> (sy[SY_SYNC] && !$past(sy[SY_SYNC], 1)))
		else $error("strobe accepted without synchronised edge");

	a_dcs_shape: assert property (@(posedge core_clk) disable iff (rst)
		(st_r.dcs_on && st_r.pwr.clk_en) |-> (st_r.conv_clk == (st_r.cnt <= (st_r.div_m1 >> 1))))
		else $error("stabilized clock not half period");

	a_dcs_bypass: assert property (@(posedge core_clk) disable iff (rst)
		(clk_on && !dcs_active) |=> (st_r.conv_clk == st_r.conv_en))
		else $error("unlocked stabilizer not bypassed");

	a_relock_wait: assert property (@(posedge core_clk) disable iff (rst)
		lock_start |=> !st_r.dcs_on [*8])
		else $error("stabilizer engaged before relock");

	a_pd_drivers: assert property (@(posedge core_clk) disable iff (rst)
		pd_any |=> (!st_r.pwr.drv_oe && !st_r.pwr.clk_en && !st_r.pwr.ref_en))
		else $error("power-down left drivers or reference on");

	a_stby_ref: assert property (@(posedge core_clk) disable iff (rst)
		stby |=> (st_r.pwr.ref_en && !st_r.pwr.bias_en && !st_r.conv_en))
		else $error("standby state wrong");

	a_wake_delay: assert property (@(posedge core_clk) disable iff (rst)
		wake_start |=> !st_r.pwr.ready [*8])
		else $error("ready without recharge interval");

	a_div_write: assert property (@(posedge core_clk) disable iff (rst)
		(wr_commit && st_r.addr == REG_DIV) |=> (st_r.div_m1 == $past(sh_in[2:0], 1)))
		else $error("divide ratio write not applied");

endmodule
`default_nettype wire

// ==== scd_pkg.sv ====
// Purpose: constants and carrier types for sample clock divide, duty cycle and power control
// Assumes: one 100 MHz core clock standing in for the sample clock
// Notes:   register map reached over the three-wire serial control port
// Function
// - Divide sample clock by integer one to eight
// - Two bits choose every strobe or first-after-write
// - Accepted strobe returns divider to initial count
// - Alignment strobe synchronised before use
// - Stabilizer regenerates falling edge, nominal half duty
// - Stabilizer loop inactive below about 20 MHz
// - Unlocked stabilizer is bypassed, raw duty used
// - Power-down from pin high or port bit
// - Output drivers high impedance during power-down
// - Pin low returns device to the mode set over the port
// - Power-down stops reference, bias, clock; recharge after
// - Port-only standby keeps reference on, faster wake
package scd_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_MHZ        = 100;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int DCS_MIN_MHZ    = 20;
	localparam bit DCS_RATE_OK    = (CLK_MHZ >= DCS_MIN_MHZ);
	localparam int LOCK_TIME_NS   = 5000;
	localparam int LOCK_CYC       = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W          = 12;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [12:0] REG_PWR   = 13'h0008;
	localparam logic [12:0] REG_DCS   = 13'h0009;
	localparam logic [12:0] REG_STAT  = 13'h000A;
	localparam logic [12:0] REG_DIV   = 13'h000B;
	localparam logic [12:0] REG_ALIGN = 13'h0100;

	localparam int ALIGN_EN_BIT   = 1;
	localparam int ALIGN_ONCE_BIT = 2;
	localparam int DCS_EN_BIT     = 0;

	localparam logic [1:0] PWR_NORMAL = 2'h0;
	localparam logic [1:0] PWR_DOWN   = 2'h1;
	localparam logic [1:0] PWR_STBY   = 2'h2;

	localparam logic [2:0] DIV_M1_RST = 3'h0;
	localparam logic [1:0] ALIGN_RST  = 2'h0;
	localparam logic       DCS_RST    = 1'b0;

	// Serial frame: 16 header bits then 8 data bits
	localparam logic [4:0] HDR_BITS   = 5'h10;
	localparam logic [4:0] FRAME_BITS = 5'h18;
	localparam int RW_BIT = 15;

	// Synchroniser lanes
	localparam int SY_SCLK = 0;
	localparam int SY_CSB  = 1;
	localparam int SY_SDIO = 2;
	localparam int SY_SYNC = 3;
	localparam int SY_LOW_POWER_REQUEST_PIN = 4;
	localparam int SY_W    = 5;
	localparam logic [SY_W-1:0] SY_RST = 5'h02;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic ref_en;
		logic bias_en;
		logic clk_en;
		logic drv_oe;
		logic ready;
	} scd_pwr_t;

	typedef struct packed {
		logic [4:0]  bitcnt;
		logic        rd;
		logic [12:0] addr;
		logic [15:0] sh;
		logic        sclk_d;
		logic        sync_d;
		logic [1:0]  align_ctl;
		logic [2:0]  div_m1;
		logic        dcs_en;
		logic [1:0]  pwr_mode;
		logic        armed;
		logic [2:0]  cnt;
		logic        lp_d;
		logic        pd_d;
		logic        dcs_on;
		logic        conv_en;
		logic        conv_clk;
		logic        sdio_out;
		logic        sdio_oe;
		scd_pwr_t    pwr;
	} scd_state_t;

endpackage

// ==== scd_sync2.sv ====
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module scd_sync2 #(
	parameter int              W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	input  wire logic          core_clk,
	input  wire logic          rst,
	input  wire logic [W-1:0]  d,
	output logic      [W-1:0]  q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} scd_sy_t;

	scd_sy_t st_r;
	scd_sy_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= {RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule
`default_nettype wire

// ==== scd_timer.sv ====
// Purpose: loadable down counter with registered done flag
// Assumes: start is a one-cycle pulse
// Notes:   done stays high until the next start
`timescale 1ns/100ps
`default_nettype none
module scd_timer #(
	parameter int W = 12
) (
	input  wire logic          core_clk,
	input  wire logic          rst,
	input  wire logic          start,
	input  wire logic [W-1:0]  load,
	output logic               done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} scd_tm_t;

	scd_tm_t st_r;
	scd_tm_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (start) begin
			st_nxt.cnt  = load;
			st_nxt.done = (load == '0);
		end else if (st_r.cnt != '0) begin
			st_nxt.cnt  = st_r.cnt - 1'b1;
			st_nxt.done = (st_r.cnt == {{(W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= '{cnt: '0, done: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign done = st_r.done;
endmodule
`default_nettype wire

// ==== scd_sys_model.sv ====
// Purpose: far side model: serial port master, strobe and power pin driver
// Assumes: every pin launched on a core_clk rising edge
// Notes:   released data line toggles so a stale bit is never read back
`timescale 1ns/100ps
`default_nettype none
module scd_sys_model (
	input  wire logic core_clk,
	input  wire logic sdio_out,
	input  wire logic sdio_oe,
	output logic      sclk_pin,
	output logic      csb_n_pin,
	output logic      sdio_in,
	output logic      align_strobe_pin,
	output logic      low_power_request_pin
);
	logic m_oe;
	logic m_d;
	logic m_flt = 1'b0;

	initial begin
		sclk_pin = 1'b0;
		csb_n_pin = 1'b1;
		align_strobe_pin = 1'b0;
		low_power_request_pin = 1'b0;
		m_oe = 1'b0;
		m_d = 1'b0;
	end

	always @(posedge core_clk) begin
		m_flt <= ~m_flt;
	end

	// Wire level from both parties' enables
	assign sdio_in = sdio_oe ? sdio_out : (m_oe ? m_d : m_flt);

	// ****************
	// Serial frame, six core cycles per phase
	// ****************
	task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [23:0] f;
		f = {rd, 2'b00, a, wd};
		q = 8'h00;
		@(posedge core_clk);
		csb_n_pin <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			@(posedge core_clk);
			sclk_pin <= 1'b0;
			m_oe <= !(rd && i < 8);
			m_d <= f[i];
			repeat (5) @(posedge core_clk);
			@(negedge core_clk);
			if (i < 8) begin
				q[i] = sdio_in;
			end
			@(posedge core_clk);
			sclk_pin <= 1'b1;
			repeat (5) @(posedge core_clk);
		end
		@(posedge core_clk);
		sclk_pin <= 1'b0;
		repeat (5) @(posedge core_clk);
		csb_n_pin <= 1'b1;
		m_oe <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask

	// Strobe launched on the clock so every part sees the same edge
	task automatic strobe();
		@(posedge core_clk);
		align_strobe_pin <= 1'b1;
		repeat (2) @(posedge core_clk);
		align_strobe_pin <= 1'b0;
	endtask

	task automatic set_lp(input logic v);
		@(posedge core_clk);
		low_power_request_pin <= v;
	endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for divider, stabilizer and power control
// Assumes: shortened standby wake count, default recharge
// Notes:   every pin is driven through the far side model
`timescale 1ns/100ps
`default_nettype none
module tb
	import scd_pkg::*;
;
	logic       core_clk;
	logic       rst;
	logic       sclk_pin;
	logic       csb_n_pin;
	logic       sdio_in;
	logic       sdio_out;
	logic       sdio_oe;
	logic       align_strobe_pin;
	logic       low_power_request_pin;
	logic       conv_en;
	logic       conv_clk;
	scd_pwr_t   pwr;
	int         error_cnt = 0;
	int         n_checks = 0;
	logic [7:0] actl [4] = '{8'h02, 8'h06, 8'h00, 8'h04};
	logic [1:0] aexp [4] = '{2'b11, 2'b10, 2'b00, 2'b00};

	scd_clock_power #(.STBY_WAKE_CYC(8)) u_dut (
		.core_clk(core_clk),
		.rst(rst),
		.sclk_pin(sclk_pin),
		.csb_n_pin(csb_n_pin),
		.sdio_in(sdio_in),
		.sdio_out(sdio_out),
		.sdio_oe(sdio_oe),
		.align_strobe_pin(align_strobe_pin),
		.low_power_request_pin(low_power_request_pin),
		.conv_en(conv_en),
		.conv_clk(conv_clk),
		.pwr(pwr)
	);

	scd_sys_model u_sys (
		.core_clk(core_clk),
		.sdio_out(sdio_out),
		.sdio_oe(sdio_oe),
		.sclk_pin(sclk_pin),
		.csb_n_pin(csb_n_pin),
		.sdio_in(sdio_in),
		.align_strobe_pin(align_strobe_pin),
		.low_power_request_pin(low_power_request_pin)
	);

	// ****************
	// Helpers
	// ****************
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_sys.xfer(1'b0, a, d, q);
	endtask

	task automatic rdchk(input string nm, input logic [12:0] a, input logic [7:0] e);
		logic [7:0] q;
		u_sys.xfer(1'b1, a, 8'h00, q);
		chk(nm, e, q);
	endtask

	task automatic pchk(input string nm, input logic [7:0] e, input int c);
		repeat (c) @(posedge core_clk);
		@(negedge core_clk);
		chk(nm, e, {3'h0, pwr});
	endtask

	task automatic wait_conv();
		@(negedge core_clk);
		for (int i = 0; i < 20 && conv_en !== 1'b1; i++) begin
			@(negedge core_clk);
		end
	endtask

	// Period and high cycles of one divided period; 20 means no pulse
	task automatic meas(output int n, output int h);
		wait_conv();
		n = 0;
		h = 0;
		do begin
			@(negedge core_clk);
			n++;
			h += int'(conv_clk);
		end while (conv_en !== 1'b1 && n < 20);
	endtask

	// Strobe placed off the natural pulse grid, so only a realign lands here
	task automatic align_try(input logic e);
		@(posedge core_clk);
		u_sys.strobe();
		@(posedge core_clk);
		@(negedge core_clk);
		chk("aligned", {7'h00, e}, {7'h00, conv_en});
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		repeat (30000) @(posedge core_clk);
		error_cnt++;
		print_verdict();
	end

	// ****************
	// Tests
	// ****************
	initial begin
		int n;
		int h;
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		rdchk("div", REG_DIV, 8'h00);
		rdchk("stab", REG_DCS, 8'h00);
		rdchk("align", REG_ALIGN, 8'h00);
		rdchk("mode", REG_PWR, 8'h00);
		rdchk("stat", REG_STAT, 8'h04);
		rdchk("unmapped", 13'h00C1, 8'h00);
		wr(REG_DCS, 8'h01);
		for (int r = 1; r <= 8; r++) begin
			wr(REG_DIV, 8'(r - 1));
			meas(n, h);
			chk("period", 8'(r), 8'(n));
			rdchk("div rb", REG_DIV, 8'(r - 1));
		end
		wr(REG_DIV, 8'h04);
		meas(n, h);
		chk("raw high", 8'h01, 8'(h));
		rdchk("unlocked", REG_STAT, 8'h04);
		repeat (LOCK_CYC) @(posedge core_clk);
		rdchk("locked", REG_STAT, 8'h0C);
		meas(n, h);
		chk("shaped high", 8'h03, 8'(h));
		wr(REG_DIV, 8'h07);
		for (int m = 0; m < 4; m++) begin
			wr(REG_ALIGN, actl[m]);
			rdchk("align rb", REG_ALIGN, actl[m]);
			wait_conv();
			align_try(aexp[m][1]);
			align_try(aexp[m][0]);
		end
		wr(REG_DIV, 8'h03);
		wr(REG_DCS, 8'h00);
		meas(n, h);
		chk("stab off period", 8'h04, 8'(n));
		chk("stab off", 8'h01, 8'(h));
		u_sys.set_lp(1'b1);
		pchk("pin down", 8'h00, 4);
		meas(n, h);
		chk("clock stopped", 8'h14, 8'(n));
		u_sys.set_lp(1'b0);
		pchk("pin wake", 8'h1E, 6);
		pchk("pin ready", 8'h1F, 2010);
		wr(REG_PWR, 8'h01);
		pchk("port down", 8'h00, 0);
		wr(REG_PWR, 8'h00);
		pchk("port wake", 8'h1E, 0);
		pchk("port ready", 8'h1F, 2010);
		wr(REG_PWR, 8'h02);
		pchk("standby", 8'h12, 0);
		u_sys.set_lp(1'b1);
		pchk("pin over", 8'h00, 4);
		u_sys.set_lp(1'b0);
		pchk("back standby", 8'h12, 6);
		wr(REG_PWR, 8'h00);
		pchk("fast wake", 8'h1F, 0);
		print_verdict();
	end
endmodule
`default_nettype wire
